// file: hw/tgw_timer_group.sv
`timescale 1ns/1ps
// Notes on behaviour
// - timer time base is a 64-bit counter
// - tick comes from 16-bit prescaler, divide 2 to 65536
// - up/down select chooses increment or decrement per tick
// - halt holds the count; resume continues from the held value
// - reload on alarm if auto-reload enabled, and on software reload command
// - alarm interrupt is either held level or single-cycle pulse
// - two main watchdogs here plus one always-on domain watchdog
// - four stages, each configurable or disabled independently
// - each stage has its own timeout, 32-bit expiry counter
// - stage expiry performs its action: interrupt, cpu, core or system reset
// - only the always-on watchdog may issue system reset
// - watchdog config writes ignored unless protection first unlocked
// - flash boot starts always-on and first main watchdog automatically
// - flash boot not finished in time reboots whole system
module tgw_timer_group #(
  parameter int unsigned NWDT = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tgw_pkg::tgw_tmr_cfg_s tmr_cfg_i,
  input wire logic tmr_reload_i,
  input wire logic tmr_int_clr_i,
  input wire logic wp_key_wr_i,
  input wire logic [15:0] wp_key_i,
  input wire logic [NWDT-1:0] wdt_cfg_wr_i,
  input wire tgw_pkg::tgw_wdt_cfg_s wdt_cfg_i,
  input wire logic [NWDT-1:0] wdt_feed_i,
  input wire logic [NWDT-1:0] wdt_int_clr_i,
  input wire logic flash_boot_i,
  input wire logic boot_done_i,
  output logic [tgw_pkg::TMR_W-1:0] tmr_count_o,
  output logic tmr_int_o,
  output logic wp_locked_o,
  output tgw_pkg::tgw_wdt_out_s [NWDT-1:0] wdt_out_o,
  output logic [NWDT-1:0][1:0] wdt_stage_o
);
  // index NWDT-1 is the always-on domain watchdog, index 0 the first main one
  localparam int unsigned AON = NWDT - 1;
  // stage count mirrored locally so the reset defaults can size the timeouts
  localparam int unsigned STAGES = tgw_pkg::STAGES;

  // all state sits in one struct: the comb block edits a copy and the
  // register stage takes it whole, so no field can miss its flop
  // limitation: the stage output is decoded from the gray-coded state,
  // so it is one small decode behind the stage register

  typedef struct packed {
    logic [tgw_pkg::TMR_W-1:0] cnt;
    logic [tgw_pkg::PRE_W-1:0] pre;
    logic irq;
    logic locked;
    logic boot_armed;
    tgw_pkg::tgw_wdt_cfg_s [NWDT-1:0] cfg;
    logic [NWDT-1:0][tgw_pkg::WDT_W-1:0] wcnt;
    tgw_pkg::tgw_stage_e [NWDT-1:0] stage;
    tgw_pkg::tgw_wdt_out_s [NWDT-1:0] wout;
  } tgw_state_s;

  tgw_state_s s_reg;
  tgw_state_s s_next;

  // stage walk 0,1,2,3 then back to 0; the last stage wraps so that an
  // unfed watchdog keeps repeating its escalation rather than parking
  function automatic tgw_pkg::tgw_stage_e next_stage(
    input tgw_pkg::tgw_stage_e st);
    case (st)
      tgw_pkg::TGW_ST0: next_stage = tgw_pkg::TGW_ST1;
      tgw_pkg::TGW_ST1: next_stage = tgw_pkg::TGW_ST2;
      tgw_pkg::TGW_ST2: next_stage = tgw_pkg::TGW_ST3;
      default: next_stage = tgw_pkg::TGW_ST0;
    endcase
  endfunction

  // gray state to plain index, used to pick the per-stage action and timeout
  function automatic logic [1:0] stage_idx(input tgw_pkg::tgw_stage_e st);
    case (st)
      tgw_pkg::TGW_ST0: stage_idx = 2'h0;
      tgw_pkg::TGW_ST1: stage_idx = 2'h1;
      tgw_pkg::TGW_ST2: stage_idx = 2'h2;
      default: stage_idx = 2'h3;
    endcase
  endfunction

  logic tick;
  logic alarm_hit;
  logic [tgw_pkg::PRE_W-1:0] div_eff;
  logic [1:0] si;
  logic [1:0] act;

  always_comb begin
    s_next = s_reg;
    tick = 1'b0;
    alarm_hit = 1'b0;
    si = 2'h0;
    act = 2'h0;
    // divider 0 means 65536; 1 is raised to the minimum of 2
    div_eff = tmr_cfg_i.div;
    if (div_eff == 16'h0001) begin
      div_eff = tgw_pkg::PRE_MIN;
    end
    if (tmr_cfg_i.en) begin
      if (s_reg.pre == div_eff - 16'h0001) begin
        s_next.pre = '0;
        tick = 1'b1;
      end else begin
        s_next.pre = s_reg.pre + 16'h0001;
      end
    end
    if (tick) begin
      if (tmr_cfg_i.up) begin
        s_next.cnt = s_reg.cnt + 64'h1;
      end else begin
        s_next.cnt = s_reg.cnt - 64'h1;
      end
    end
    // alarm compares the value the counter is about to take, so the
    // interrupt and any reload land on the same edge as the match
    alarm_hit = tick && tmr_cfg_i.alarm_en &&
      (s_next.cnt == tmr_cfg_i.alarm);
    if (tmr_reload_i || (alarm_hit && tmr_cfg_i.autoreload)) begin
      s_next.cnt = tmr_cfg_i.load;
    end
    // a software reload wins over the tick and over the alarm reload
    // level mode: an alarm in the same cycle as a clear keeps the flag set
    if (tmr_cfg_i.level_int) begin
      if (alarm_hit) begin
        s_next.irq = 1'b1;
      end else if (tmr_int_clr_i) begin
        s_next.irq = 1'b0;
      end
    end else begin
      s_next.irq = alarm_hit;
    end

    // write protection: correct key unlocks, any other key relocks
    if (wp_key_wr_i) begin
      s_next.locked = (wp_key_i != tgw_pkg::WP_KEY);
    end
    if (boot_done_i) begin
      s_next.boot_armed = 1'b0;
    end

    // reset requests are one-cycle pulses; the watchdog irq is a level that
    // a clear drops unless an expiry sets it again in the same cycle
    for (int w = 0; w < NWDT; w++) begin
      si = stage_idx(s_reg.stage[w]);
      act = s_reg.cfg[w].act[si];
      s_next.wout[w].cpu_rst = 1'b0;
      s_next.wout[w].core_rst = 1'b0;
      s_next.wout[w].sys_rst = 1'b0;
      if (wdt_int_clr_i[w]) begin
        s_next.wout[w].irq = 1'b0;
      end
      if (wdt_cfg_wr_i[w] && !s_reg.locked) begin
        s_next.cfg[w] = wdt_cfg_i;
        s_next.cfg[w].sys_reset_ok = (w == AON);
        s_next.wcnt[w] = '0;
        s_next.stage[w] = tgw_pkg::TGW_ST0;
      end else if (wdt_feed_i[w] || !s_reg.cfg[w].en) begin
        s_next.wcnt[w] = '0;
        s_next.stage[w] = tgw_pkg::TGW_ST0;
      end else if (s_reg.wcnt[w] >= s_reg.cfg[w].tmo[si]) begin
        s_next.wcnt[w] = '0;
        s_next.stage[w] = next_stage(s_reg.stage[w]);
        case (act)
          tgw_pkg::TGW_ACT_INT: s_next.wout[w].irq = 1'b1;
          tgw_pkg::TGW_ACT_CPU: s_next.wout[w].cpu_rst = 1'b1;
          tgw_pkg::TGW_ACT_CORE: s_next.wout[w].core_rst = 1'b1;
          default: s_next.wout[w].irq = s_next.wout[w].irq;
        endcase
        // last stage of the always-on watchdog escalates to full reset
        if (s_reg.cfg[w].sys_reset_ok && act != tgw_pkg::TGW_ACT_OFF &&
            s_reg.stage[w] == tgw_pkg::TGW_ST3) begin
          s_next.wout[w].sys_rst = 1'b1;
        end
      end else begin
        s_next.wcnt[w] = s_reg.wcnt[w] + 32'h1;
      end
    end

    // boot arming: the always-on and first main watchdog run on their own
    if (flash_boot_i && s_reg.boot_armed && !boot_done_i) begin
      s_next.cfg[0].en = 1'b1;
      s_next.cfg[AON].en = 1'b1;
      s_next.cfg[AON].sys_reset_ok = 1'b1;
    end
  end

  // reset leaves every watchdog disabled with the slowest timeouts, so a
  // stray enable cannot fire until the longest timeout has run out
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.locked <= 1'b1;
      s_reg.boot_armed <= 1'b1;
      for (int w = 0; w < NWDT; w++) begin
        s_reg.cfg[w].act <= {tgw_pkg::TGW_ACT_CPU, tgw_pkg::TGW_ACT_CPU,
          tgw_pkg::TGW_ACT_CPU, tgw_pkg::TGW_ACT_CPU};
        s_reg.cfg[w].tmo <= {STAGES{32'hFFFF_FFFF}};
      end
    end else begin
      s_reg <= s_next;
    end
  end

  assign tmr_count_o = s_reg.cnt;
  assign tmr_int_o = s_reg.irq;
  assign wp_locked_o = s_reg.locked;
  assign wdt_out_o = s_reg.wout;
  always_comb begin
    for (int w = 0; w < NWDT; w++) begin
      wdt_stage_o[w] = stage_idx(s_reg.stage[w]);
    end
  end
endmodule

// file: pkg/tgw_pkg.sv
package tgw_pkg;
  localparam int unsigned TMR_W = 64;
  localparam int unsigned PRE_W = 16;
  localparam int unsigned WDT_W = 32;
  localparam int unsigned STAGES = 4;
  localparam logic [PRE_W-1:0] PRE_MIN = 16'h0002;
  localparam logic [15:0] WP_KEY = 16'h50D1;

  typedef enum logic [1:0] {
    TGW_ACT_OFF = 2'h0,
    TGW_ACT_INT = 2'h1,
    TGW_ACT_CPU = 2'h2,
    TGW_ACT_CORE = 2'h3
  } tgw_act_e;

  typedef enum logic [1:0] {
    TGW_ST0 = 2'h0,
    TGW_ST1 = 2'h1,
    TGW_ST2 = 2'h3,
    TGW_ST3 = 2'h2
  } tgw_stage_e;

  typedef struct packed {
    logic en;
    logic up;
    logic autoreload;
    logic alarm_en;
    logic level_int;
    logic [PRE_W-1:0] div;
    logic [TMR_W-1:0] alarm;
    logic [TMR_W-1:0] load;
  } tgw_tmr_cfg_s;

  typedef struct packed {
    logic en;
    logic sys_reset_ok;
    logic [STAGES-1:0][1:0] act;
    logic [STAGES-1:0][WDT_W-1:0] tmo;
  } tgw_wdt_cfg_s;

  typedef struct packed {
    logic irq;
    logic cpu_rst;
    logic core_rst;
    logic sys_rst;
  } tgw_wdt_out_s;
endpackage

// file: verif/tgw_timer_group_sva.sv
`timescale 1ns/1ps
module tgw_timer_group_sva #(parameter int unsigned NWDT = 3) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tgw_pkg::tgw_tmr_cfg_s tmr_cfg_i,
  input wire logic tmr_reload_i,
  input wire logic tmr_int_clr_i,
  input wire logic wp_key_wr_i,
  input wire logic [15:0] wp_key_i,
  input wire logic [NWDT-1:0] wdt_feed_i,
  input wire logic [tgw_pkg::TMR_W-1:0] tmr_count_o,
  input wire logic tmr_int_o,
  input wire logic wp_locked_o,
  input wire tgw_pkg::tgw_wdt_out_s [NWDT-1:0] wdt_out_o,
  input wire logic [NWDT-1:0][1:0] wdt_stage_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RELOAD: assert property (
    tmr_reload_i |=> tmr_count_o == $past(tmr_cfg_i.load)) else $error("load");
  AST_HALT: assert property (
    !tmr_cfg_i.en && !tmr_reload_i |=> $stable(tmr_count_o)) else $error("halt");
  AST_STEP: assert property (
    $changed(tmr_count_o) && !$past(tmr_reload_i) && !$past(tmr_cfg_i.autoreload)
    |-> tmr_count_o == ($past(tmr_cfg_i.up) ? $past(tmr_count_o) + 64'h1
    : $past(tmr_count_o) - 64'h1)) else $error("step");
  AST_PULSE: assert property (
    $rose(tmr_int_o) && !tmr_cfg_i.level_int |=> !tmr_int_o) else $error("pulse");
  AST_LEVEL: assert property (
    tmr_int_o && tmr_cfg_i.level_int && !tmr_int_clr_i |=> tmr_int_o)
    else $error("level");
  AST_UNLOCK: assert property (
    wp_key_wr_i && wp_key_i == tgw_pkg::WP_KEY |=> !wp_locked_o) else $error("key");
  AST_RELOCK: assert property (
    wp_key_wr_i && wp_key_i != tgw_pkg::WP_KEY |=> wp_locked_o) else $error("lock");
  AST_FEED: assert property (
    wdt_feed_i[0] |=> wdt_stage_o[0] == 2'h0) else $error("feed");
  AST_NOSYS: assert property (!wdt_out_o[0].sys_rst) else $error("sys");
  AST_STAGE: assert property (
    $changed(wdt_stage_o[0]) |-> wdt_stage_o[0] == 2'h0
    || wdt_stage_o[0] == $past(wdt_stage_o[0]) + 2'h1) else $error("stage");
  cover property (tmr_int_o && tmr_cfg_i.level_int);
  cover property ($rose(wdt_out_o[0].irq));
  cover property (!wp_locked_o);
endmodule
bind tgw_timer_group tgw_timer_group_sva #(.NWDT(NWDT)) u_sva (.*);

// file: verif/tb_tgw_timer_group.sv
`timescale 1ns/1ps
module tb_tgw_timer_group;
  logic clk_i = 1'b0;
  logic rst_i, tmr_reload_i, tmr_int_clr_i, wp_key_wr_i, flash_boot_i;
  logic boot_done_i, tmr_int_o, wp_locked_o, pw, pt;
  logic [15:0] wp_key_i;
  logic [2:0] wdt_cfg_wr_i, wdt_feed_i, wdt_int_clr_i;
  logic [63:0] tmr_count_o, v, d;
  logic [31:0] s = 32'h0000441C;
  logic [2:0][1:0] wdt_stage_o;
  tgw_pkg::tgw_tmr_cfg_s tmr_cfg_i;
  tgw_pkg::tgw_wdt_cfg_s wdt_cfg_i;
  tgw_pkg::tgw_wdt_out_s [2:0] wdt_out_o;
  int fail_count, tests_run, cyc, c, dv, t;
  int q[$];
  tgw_timer_group u_dut (.*);
  initial forever #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task complete_run();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one-cycle strobe; the bench holds the data until the edge has sampled it
  task pul(input int k, input logic [2:0] m);
    case (k)
      0: tmr_reload_i <= 1'b1;
      1: wp_key_wr_i <= 1'b1;
      2: wdt_cfg_wr_i <= m;
      3: wdt_feed_i <= m;
      default: tmr_int_clr_i <= 1'b1;
    endcase
    cy(1);
    {tmr_reload_i, wp_key_wr_i, tmr_int_clr_i} <= '0;
    {wdt_cfg_wr_i, wdt_feed_i} <= '0;
    cy(1);
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // every observed event must match the oldest expected event code
  always @(posedge clk_i) if (!rst_i) begin
    c = wdt_out_o[0].cpu_rst ? 2 : wdt_out_o[0].core_rst ? 3 : 0;
    if (wdt_out_o[2].sys_rst) c = 4;
    if (wdt_out_o[0].irq && !pw) c = 1;
    if (tmr_int_o && !pt) c = 5;
    pw = wdt_out_o[0].irq;
    pt = tmr_int_o;
    if (c != 0) chk("event", c, q.size() ? q.pop_front() : 0);
  end
  initial begin
    {rst_i, pw, pt, cyc} = '1;
    {tmr_reload_i, tmr_int_clr_i, wp_key_wr_i, flash_boot_i, boot_done_i} = '0;
    {wp_key_i, wdt_cfg_wr_i, wdt_feed_i, wdt_int_clr_i, tmr_cfg_i} = '0;
    {wdt_cfg_i, fail_count, tests_run, cyc} = '0;
    cy(12);
    rst_i <= 1'b0;
    dv = 2 + xs() % 4;
    tmr_cfg_i.div <= 16'(dv);
    tmr_cfg_i.load <= {xs(), xs()};
    pul(0, 0);
    chk("load", tmr_count_o, tmr_cfg_i.load);
    for (int u = 1; u >= 0; u--) begin
      v = tmr_count_o;
      tmr_cfg_i.up <= u[0];
      tmr_cfg_i.en <= 1'b1;
      cy(10 * dv);
      tmr_cfg_i.en <= 1'b0;
      cy(2);
      d = u ? tmr_count_o - v : v - tmr_count_o;
      chk("ticks", 64'(d >= 9 && d <= 11), 1);
      v = tmr_count_o;
      cy(20);
      chk("halt", tmr_count_o, v);
    end
    // alarm five ticks ahead: a reload keeps the count below the alarm
    for (int lv = 1; lv >= 0; lv--) begin
      pul(0, 0);
      tmr_cfg_i <= '{1'b1, 1'b1, 1'b1, 1'b1, lv[0], 16'(dv),
        tmr_count_o + 64'h5, tmr_cfg_i.load};
      q.push_back(5);
      cy(7 * dv);
      tmr_cfg_i.en <= 1'b0;
      tmr_cfg_i.alarm_en <= 1'b0;
      cy(2);
      chk("irq", tmr_int_o, lv[0]);
      chk("rld", 64'(tmr_count_o - tmr_cfg_i.load < 5), 1);
      pul(4, 0);
      chk("clr", tmr_int_o, 0);
    end
    t = 4 + xs() % 4;
    wdt_cfg_i <= '{1'b1, 1'b0, {2'h0, 2'h3, 2'h2, 2'h1}, {4{32'(t)}}};
    chk("lock", wp_locked_o, 1);
    pul(2, 3'h1);
    cy(5 * t);
    chk("refuse", wdt_stage_o[0], 0);
    wp_key_i <= tgw_pkg::WP_KEY;
    pul(1, 0);
    chk("unlock", wp_locked_o, 0);
    q = {1, 2, 3};
    pul(2, 3'h1);
    cy(t + 3);
    pul(3, 3'h1);
    cy(3 * t + 6);
    chk("stage", wdt_stage_o[0], 3);
    wdt_cfg_i.en <= 1'b0;
    pul(2, 3'h1);
    wdt_int_clr_i <= 3'h1;
    cy(1);
    wdt_int_clr_i <= 3'h0;
    cy(5 * t);
    chk("wirq", wdt_out_o[0].irq, 0);
    wdt_cfg_i <= '{1'b1, 1'b0, {2'h2, 2'h0, 2'h0, 2'h0}, {4{32'(t)}}};
    q.push_back(4);
    pul(2, 3'h4);
    cy(4 * t + 6);
    chk("left", q.size(), 0);
    // flash boot strap arms the first main watchdog without a config write
    q.push_back(1);
    flash_boot_i <= 1'b1;
    cy(t + 4);
    chk("boot", wdt_stage_o[0], 1);
    chk("bootirq", q.size(), 0);
    complete_run();
  end
endmodule
